// ### duart_defines.svh
// offsets, field positions and reset values of the dual uart host port
`ifndef DUART_DEFINES_SVH
`define DUART_DEFINES_SVH
// ****************************************
// per-channel word indices (haddr[5:2])
// ****************************************
`define W_DATA 4'h0
`define W_DIV_LO 4'h1
`define W_DIV_HI 4'h2
`define W_DIV_FRAC 4'h3
`define W_FCR 4'h4
`define W_LSR 4'h5
`define W_FEATURE_CONTROL_REG 4'h6
`define W_TX_TRIG 4'h7
`define W_RX_TRIG 4'h8
`define W_MEM_BASE 4'h9
`define W_MEM_LAST 4'hf
// ****************************************
// global word indices (haddr[7] set)
// ****************************************
`define W_IRQ_STAT 4'h0
`define W_IRQ_MASK 4'h1
`define W_PIN_STAT 4'h2
// ****************************************
// address bits
// ****************************************
`define A_GLOBAL 7
`define A_PICK 6
// ****************************************
// field positions
// ****************************************
`define FCR_FIFO_EN 0
`define FCR_BLOCK 3
`define FEATURE_CONTROL_REG_AUTODIR 3
`define LSR_RX_READY 0
`define LSR_ROOM 5
`define LSR_EMPTY 6
// ****************************************
// reset values
// ****************************************
`define DIV_LO_RST 8'h01
`define DIV_HI_RST 8'h00
`define DIV_FRAC_RST 4'h0
`define FCR_RST 8'h00
`define FEATURE_CONTROL_REG_RST 8'h00
`define TRIG_RST 7'h01
`define MASK_RST 4'h0
`endif

// ### duart_pkg.sv
// types and helpers shared by the dual uart host port
package duart_pkg;
	// fifo fill level, 0 to 64
	typedef logic [6:0] level_t;
	// bus slave phase
	typedef enum logic {BUS_IDLE = 1'b0, BUS_DATA = 1'b1} bus_state_e;
	// level at or above a trigger threshold
	function automatic logic at_or_above(input level_t c, input level_t t);
		at_or_above = (c >= t);
	endfunction
endpackage

// ### chan_if.sv
// configuration and pin state of one channel between top and signaller
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
	// configuration from the register file
	logic fifo_en;
	logic block_mode;
	logic auto_dir;
	duart_pkg::level_t tx_trig;
	duart_pkg::level_t rx_trig;
	// fifo and shifter state
	duart_pkg::level_t rx_count;
	duart_pkg::level_t tx_count;
	logic tsr_empty;
	logic rx_timeout;
	// registered pin levels
	logic rx_rdy_n;
	logic tx_rdy_n;
	logic tx_int;
	logic rx_int;
	logic dir_rx;
	logic lsr_room;
	logic lsr_empty;
	modport ctl (
		output fifo_en, block_mode, auto_dir, tx_trig, rx_trig,
		output rx_count, tx_count, tsr_empty, rx_timeout,
		input rx_rdy_n, tx_rdy_n, tx_int, rx_int, dir_rx,
		input lsr_room, lsr_empty
	);
	modport sig (
		input fifo_en, block_mode, auto_dir, tx_trig, rx_trig,
		input rx_count, tx_count, tsr_empty, rx_timeout,
		output rx_rdy_n, tx_rdy_n, tx_int, rx_int, dir_rx,
		output lsr_room, lsr_empty
	);
endinterface
`default_nettype wire

// ### reg_mem.sv
// small register memory for plain per-channel bytes, registered read
`timescale 1ns/1ps
`default_nettype none
module reg_mem #(
	parameter int AW = 4,
	parameter int DW = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// read port
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	// storage words
	logic [DW-1:0] mem_reg [2**AW];

	// write, cleared to zero by reset
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < 2**AW; i++)
				mem_reg[i] <= '0;
		end
		else if (ce && we)
			mem_reg[waddr] <= wdata;
	end

	// read data out of a register
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdata <= '0;
		else if (ce)
			rdata <= mem_reg[raddr];
	end
endmodule
`default_nettype wire

// ### chan_signal.sv
// ready, interrupt, direction and line status levels of one channel
`timescale 1ns/1ps
`default_nettype none
module chan_signal #(
	parameter duart_pkg::level_t FIFO_DEPTH = 7'd64
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// channel state and levels
	chan_if.sig ch
);
	// block-mode receive request latch
	logic blk_rx_reg;
	logic blk_rx_next;
	logic tx_all_empty;

	assign tx_all_empty = (ch.tx_count == '0) && ch.tsr_empty;

	// block receive request: set at trigger or time-out, clear on empty
	always_comb
	begin
		blk_rx_next = blk_rx_reg;
		if (ch.rx_count == '0)
			blk_rx_next = 1'b0;
		else if (duart_pkg::at_or_above(ch.rx_count, ch.rx_trig)
			|| ch.rx_timeout)
			blk_rx_next = 1'b1;
	end

	// block receive latch
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			blk_rx_reg <= 1'b0;
		else if (ce)
			blk_rx_reg <= blk_rx_next;
	end

	// ready pins only pace the host, nothing moves data itself
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ch.rx_rdy_n <= 1'b1;
			ch.tx_rdy_n <= 1'b0;
		end
		else if (ce)
		begin
			if (ch.fifo_en && ch.block_mode)
			begin
				ch.rx_rdy_n <= !blk_rx_next;
				ch.tx_rdy_n <= (ch.tx_count >= FIFO_DEPTH);
			end
			else
			begin
				// single character: byte present / holding loaded
				ch.rx_rdy_n <= (ch.rx_count == '0);
				ch.tx_rdy_n <= (ch.tx_count != '0);
			end
		end
	end

	// transmit and receive interrupt levels
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ch.tx_int <= 1'b0;
			ch.rx_int <= 1'b0;
		end
		else if (ce)
		begin
			if (!ch.fifo_en)
			begin
				// holding empty, or whole transmitter with auto direction
				if (ch.auto_dir)
					ch.tx_int <= tx_all_empty;
				else
					ch.tx_int <= (ch.tx_count == '0);
				ch.rx_int <= (ch.rx_count != '0);
			end
			else
			begin
				if (ch.auto_dir)
					ch.tx_int <= (ch.tx_count < ch.tx_trig)
						|| tx_all_empty;
				else
					ch.tx_int <= (ch.tx_count <= ch.tx_trig);
				ch.rx_int <= duart_pkg::at_or_above(ch.rx_count,
					ch.rx_trig);
			end
		end
	end

	// line status room/empty and half-duplex direction
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ch.lsr_room <= 1'b1;
			ch.lsr_empty <= 1'b1;
			ch.dir_rx <= 1'b1;
		end
		else if (ce)
		begin
			if (ch.fifo_en)
				ch.lsr_room <= (ch.tx_count < FIFO_DEPTH);
			else
				ch.lsr_room <= (ch.tx_count == '0);
			ch.lsr_empty <= tx_all_empty;
			// receive unless auto direction and still sending
			ch.dir_rx <= !ch.auto_dir || tx_all_empty;
		end
	end
endmodule
`default_nettype wire

// ### duart_host_port.sv
// dual uart host port: ahb-lite registers, ready and interrupt pins
// Function
// - reset restores all registers and outputs
// - zero integer divisor reads id/revision codes
// - unselected ignored; pick 1 is A
// - each channel owns independent register set
// - no data movement; ready pins only
// - fifo control bit 3 selects block mode
// - single mode rx ready low when data
// - block rx ready: trigger/time-out low, empty high
// - single mode tx ready low when empty
// - block tx ready low unless fifo full
// - line status 5 room, 6 empty
// - fifo tx interrupt high at/below trigger
// - auto direction: below trigger or empty
// - rx interrupt follows trigger or byte held
// - baud clock not needed for bus
// - framed transfers share one data bus
// - auto direction via feature bit 3
//
// Our own choices: the register addresses and register access over AHB-Lite.
`include "duart_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module duart_host_port #(
	parameter logic [7:0] ID_CODE = 8'h5c, // arbitrary value
	parameter logic [7:0] REV_CODE = 8'h03, // arbitrary value
	parameter duart_pkg::level_t FIFO_DEPTH = 7'd64
) (
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// fifo and shifter state, index 0 is channel a
	input wire logic [1:0][7:0] rx_data,
	input wire logic [1:0][6:0] rx_count,
	input wire logic [1:0][6:0] tx_count,
	input wire logic [1:0] tsr_empty,
	input wire logic [1:0] rx_timeout,
	// data strobes towards the fifos
	output logic [1:0] tx_push,
	output logic [1:0] rx_pop,
	output logic [7:0] tx_data,
	// baud generator settings
	output logic [1:0][15:0] baud_int,
	output logic [1:0][3:0] baud_frac,
	// channel pins
	output logic [1:0] rx_service_request_n,
	output logic [1:0] tx_service_request_n,
	output logic channel_a_irq,
	output logic channel_b_irq,
	output logic [1:0] dir_rx,
	// summary interrupt
	output logic irq
);
	// ****************************************
	// declarations
	// ****************************************
	duart_pkg::bus_state_e state_reg; // slave phase
	logic acc_write_reg; // captured direction
	logic acc_global_reg; // captured global space
	logic acc_ch_reg; // captured channel index
	logic [3:0] acc_word_reg; // captured word index
	logic take; // address phase accepted
	logic pick_ch; // channel index of haddr
	logic wr; // write in data phase
	logic rd; // read in data phase
	logic [1:0][7:0] div_lo_reg; // integer divisor low
	logic [1:0][7:0] div_hi_reg; // integer divisor high
	logic [1:0][3:0] div_frac_reg; // fractional divisor
	logic [1:0][7:0] fcr_reg; // fifo control
	logic [1:0][7:0] feature_control_reg_reg; // feature control
	logic [1:0][6:0] tx_trig_reg; // transmit trigger
	logic [1:0][6:0] rx_trig_reg; // receive trigger
	logic [3:0] irq_stat_reg; // sticky events
	logic [3:0] irq_mask_reg; // event mask
	logic [3:0] lvl_prev_reg; // previous interrupt levels
	logic [3:0] lvl_now; // current interrupt levels
	logic [3:0] rise; // rising interrupt levels
	logic mem_we; // plain register write
	logic [3:0] mem_waddr; // plain register write index
	logic [3:0] mem_raddr; // plain register read index
	logic [7:0] mem_rdata; // plain register read data
	logic [31:0] rdata_mux; // selected read word
	logic [7:0] lsr_byte [2]; // line status per channel

	// ****************************************
	// per-channel signalling
	// ****************************************
	chan_if cif[2] ();

	// wire each channel's own registers into its signaller
	for (genvar i = 0; i < 2; i++)
	begin : g_ch
		assign cif[i].fifo_en = fcr_reg[i][`FCR_FIFO_EN];
		assign cif[i].block_mode = fcr_reg[i][`FCR_BLOCK];
		assign cif[i].auto_dir = feature_control_reg_reg[i][`FEATURE_CONTROL_REG_AUTODIR];
		assign cif[i].tx_trig = tx_trig_reg[i];
		assign cif[i].rx_trig = rx_trig_reg[i];
		assign cif[i].rx_count = rx_count[i];
		assign cif[i].tx_count = tx_count[i];
		assign cif[i].tsr_empty = tsr_empty[i];
		assign cif[i].rx_timeout = rx_timeout[i];
		assign lsr_byte[i] = {1'b0, cif[i].lsr_empty, cif[i].lsr_room,
			4'h0, (rx_count[i] != '0)};
		assign lvl_now[2*i] = cif[i].rx_int;
		assign lvl_now[2*i+1] = cif[i].tx_int;
		assign rx_service_request_n[i] = cif[i].rx_rdy_n;
		assign tx_service_request_n[i] = cif[i].tx_rdy_n;
		assign dir_rx[i] = cif[i].dir_rx;
		chan_signal #(
			.FIFO_DEPTH(FIFO_DEPTH)
		) u_sig (
			.clk(sys_clk),
			.rstn(rstn),
			.ce(ce),
			.ch(cif[i].sig)
		);
	end

	// ****************************************
	// bus decode
	// ****************************************
	// pick bit high addresses channel a (index 0), low channel b
	assign pick_ch = !haddr[`A_PICK];
	// an unselected slave takes nothing and drives no strobe
	assign take = hsel && htrans[1] && hready;
	assign wr = (state_reg == duart_pkg::BUS_DATA) && acc_write_reg;
	assign rd = (state_reg == duart_pkg::BUS_DATA) && !acc_write_reg;

	// slave phase: one wait state on every transfer
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= duart_pkg::BUS_IDLE;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else if (ce)
		begin
			hresp <= 1'b0;
			unique case (state_reg)
				duart_pkg::BUS_IDLE:
				begin
					if (take)
					begin
						state_reg <= duart_pkg::BUS_DATA;
						hreadyout <= 1'b0;
					end
				end
				duart_pkg::BUS_DATA:
				begin
					state_reg <= duart_pkg::BUS_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	// address phase capture
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			acc_write_reg <= 1'b0;
			acc_global_reg <= 1'b0;
			acc_ch_reg <= 1'b0;
			acc_word_reg <= 4'h0;
		end
		else if (ce && take && state_reg == duart_pkg::BUS_IDLE)
		begin
			acc_write_reg <= hwrite;
			acc_global_reg <= haddr[`A_GLOBAL];
			acc_ch_reg <= pick_ch;
			acc_word_reg <= haddr[5:2];
		end
	end

	// ****************************************
	// channel registers
	// ****************************************
	// write into the addressed channel only
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < 2; i++)
			begin
				div_lo_reg[i] <= `DIV_LO_RST;
				div_hi_reg[i] <= `DIV_HI_RST;
				div_frac_reg[i] <= `DIV_FRAC_RST;
				fcr_reg[i] <= `FCR_RST;
				feature_control_reg_reg[i] <= `FEATURE_CONTROL_REG_RST;
				tx_trig_reg[i] <= `TRIG_RST;
				rx_trig_reg[i] <= `TRIG_RST;
			end
		end
		else if (ce && wr && !acc_global_reg)
		begin
			unique case (acc_word_reg)
				`W_DIV_LO: div_lo_reg[acc_ch_reg] <= hwdata[7:0];
				`W_DIV_HI: div_hi_reg[acc_ch_reg] <= hwdata[7:0];
				`W_DIV_FRAC: div_frac_reg[acc_ch_reg] <= hwdata[3:0];
				`W_FCR: fcr_reg[acc_ch_reg] <= hwdata[7:0];
				`W_FEATURE_CONTROL_REG: feature_control_reg_reg[acc_ch_reg] <= hwdata[7:0];
				`W_TX_TRIG: tx_trig_reg[acc_ch_reg] <= hwdata[6:0];
				`W_RX_TRIG: rx_trig_reg[acc_ch_reg] <= hwdata[6:0];
				default: ;
			endcase
		end
	end

	// divisor settings go to the baud generators; the oscillator is
	// never needed by this bus logic
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			baud_int <= {2{`DIV_HI_RST, `DIV_LO_RST}};
			baud_frac <= {2{`DIV_FRAC_RST}};
		end
		else if (ce)
		begin
			for (int i = 0; i < 2; i++)
			begin
				baud_int[i] <= {div_hi_reg[i], div_lo_reg[i]};
				baud_frac[i] <= div_frac_reg[i];
			end
		end
	end

	// data strobes: one-cycle push on data write, pop on data read
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_push <= 2'b00;
			rx_pop <= 2'b00;
			tx_data <= 8'h00;
		end
		else if (ce)
		begin
			tx_push <= 2'b00;
			rx_pop <= 2'b00;
			if (!acc_global_reg && acc_word_reg == `W_DATA)
			begin
				if (wr)
				begin
					tx_push[acc_ch_reg] <= 1'b1;
					tx_data <= hwdata[7:0];
				end
				if (rd)
					rx_pop[acc_ch_reg] <= 1'b1;
			end
		end
	end

	// ****************************************
	// plain per-channel bytes
	// ****************************************
	assign mem_we = wr && !acc_global_reg && acc_word_reg >= `W_MEM_BASE;
	assign mem_waddr = {acc_ch_reg, 3'(acc_word_reg - `W_MEM_BASE)};
	assign mem_raddr = {pick_ch, 3'(haddr[5:2] - `W_MEM_BASE)};

	reg_mem #(
		.AW(4),
		.DW(8)
	) u_mem (
		.clk(sys_clk),
		.rstn(rstn),
		.ce(ce),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(hwdata[7:0]),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// ****************************************
	// interrupts
	// ****************************************
	assign rise = lvl_now & ~lvl_prev_reg;

	// sticky events, write one to clear, a new event wins
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			lvl_prev_reg <= 4'h0;
			irq_stat_reg <= 4'h0;
			irq_mask_reg <= `MASK_RST;
		end
		else if (ce)
		begin
			lvl_prev_reg <= lvl_now;
			if (wr && acc_global_reg && acc_word_reg == `W_IRQ_STAT)
				irq_stat_reg <= (irq_stat_reg & ~hwdata[3:0]) | rise;
			else
				irq_stat_reg <= irq_stat_reg | rise;
			if (wr && acc_global_reg && acc_word_reg == `W_IRQ_MASK)
				irq_mask_reg <= hwdata[3:0];
		end
	end

	// channel pins: transmitter or receiver condition
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			channel_a_irq <= 1'b0;
			channel_b_irq <= 1'b0;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			channel_a_irq <= lvl_now[0] | lvl_now[1];
			channel_b_irq <= lvl_now[2] | lvl_now[3];
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// ****************************************
	// read data
	// ****************************************
	// read multiplexer, unmapped words read zero
	always_comb
	begin
		rdata_mux = 32'h0000_0000;
		if (acc_global_reg)
		begin
			unique case (acc_word_reg)
				`W_IRQ_STAT: rdata_mux = {28'h0, irq_stat_reg};
				`W_IRQ_MASK: rdata_mux = {28'h0, irq_mask_reg};
				`W_PIN_STAT: rdata_mux = {24'h0, dir_rx,
					tx_service_request_n, rx_service_request_n,
					channel_b_irq, channel_a_irq};
				default: rdata_mux = 32'h0000_0000;
			endcase
		end
		else
		begin
			unique case (acc_word_reg)
				`W_DATA: rdata_mux = {24'h0, rx_data[acc_ch_reg]};
				`W_DIV_LO:
				begin
					// zero integer divisor exposes revision
					if ({div_hi_reg[acc_ch_reg], div_lo_reg[acc_ch_reg]}
						== 16'h0000)
						rdata_mux = {24'h0, REV_CODE};
					else
						rdata_mux = {24'h0, div_lo_reg[acc_ch_reg]};
				end
				`W_DIV_HI:
				begin
					// zero integer divisor exposes identity
					if ({div_hi_reg[acc_ch_reg], div_lo_reg[acc_ch_reg]}
						== 16'h0000)
						rdata_mux = {24'h0, ID_CODE};
					else
						rdata_mux = {24'h0, div_hi_reg[acc_ch_reg]};
				end
				`W_DIV_FRAC: rdata_mux = {28'h0, div_frac_reg[acc_ch_reg]};
				`W_FCR: rdata_mux = {24'h0, fcr_reg[acc_ch_reg]};
				`W_LSR: rdata_mux = {24'h0, lsr_byte[acc_ch_reg]};
				`W_FEATURE_CONTROL_REG: rdata_mux = {24'h0, feature_control_reg_reg[acc_ch_reg]};
				`W_TX_TRIG: rdata_mux = {25'h0, tx_trig_reg[acc_ch_reg]};
				`W_RX_TRIG: rdata_mux = {25'h0, rx_trig_reg[acc_ch_reg]};
				default: rdata_mux = {24'h0, mem_rdata};
			endcase
		end
	end

	// read word registered at the end of the wait state
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			hrdata <= 32'h0000_0000;
		else if (ce && rd)
			hrdata <= rdata_mux;
	end
endmodule
`default_nettype wire

// ### duart_host_port_properties.sv
// port checks of the dual uart host port
`timescale 1ns/1ps
`default_nettype none
module duart_host_port_properties (
	// clock, reset and bus
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	// fifo state
	input wire logic [1:0][6:0] rx_count,
	input wire logic [1:0][6:0] tx_count,
	input wire logic [1:0] tsr_empty,
	// strobes and pins
	input wire logic [1:0] tx_push,
	input wire logic [1:0] rx_pop,
	input wire logic [1:0] rx_service_request_n,
	input wire logic [1:0] tx_service_request_n,
	input wire logic channel_a_irq,
	input wire logic [1:0] dir_rx,
	input wire logic irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// one wait cycle per taken transfer
	wait_one_a: assert property (
		ce && hsel && htrans[1] && hready && hreadyout
		|=> !hreadyout ##1 hreadyout)
		else $error("wait state not one cycle");
	unsel_idle_a: assert property (
		!hsel && hreadyout |=> hreadyout)
		else $error("unselected bus answered");
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	upper_zero_a: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	// strobes only close a transfer, one channel at a time
	strobe_end_a: assert property (
		(tx_push | rx_pop) != 2'h0 |-> $past(hreadyout) == 1'b0
		&& $onehot(tx_push | rx_pop))
		else $error("strobe outside transfer end");
	rx_empty_a: assert property (
		rx_count[0] == 7'h0 |=> rx_service_request_n[0])
		else $error("rx request with empty fifo");
	tx_full_a: assert property (
		tx_count[0] == 7'h40 |=> tx_service_request_n[0])
		else $error("tx request with full fifo");
	tx_empty_a: assert property (
		tx_count[0] == 7'h0 |=> !tx_service_request_n[0])
		else $error("no tx request with empty fifo");
	// pin trails the levels by two flops: condition, then pin register
	tx_int_a: assert property (
		tx_count[0] == 7'h0 && tsr_empty[0] |-> ##2 channel_a_irq)
		else $error("tx interrupt low while idle");
	// transmit direction only while the transmitter is busy
	dir_busy_a: assert property (
		!dir_rx[0] |-> $past(tx_count[0] != 7'h0 || !tsr_empty[0]))
		else $error("transmit direction while idle");
	// main scenarios reached
	cover property (irq);
	cover property (!dir_rx[0]);
	cover property (!rx_service_request_n[0] ##1 rx_count[0] == 7'h0);
endmodule
bind duart_host_port duart_host_port_properties chk (
	.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .hsel(hsel),
	.htrans(htrans), .hready(hready), .hreadyout(hreadyout),
	.hrdata(hrdata), .hresp(hresp), .rx_count(rx_count),
	.tx_count(tx_count), .tsr_empty(tsr_empty), .tx_push(tx_push),
	.rx_pop(rx_pop), .rx_service_request_n(rx_service_request_n),
	.tx_service_request_n(tx_service_request_n),
	.channel_a_irq(channel_a_irq), .dir_rx(dir_rx), .irq(irq));
`default_nettype wire

// ### cpu_model.sv
// host cpu model issuing single ahb-lite word transfers
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
	// clock and slave answer
	input wire logic sys_clk,
	input wire logic hreadyout,
	// master request
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// idle bus at time zero
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// one word transfer, each phase held until ready is sampled
	task automatic xfer(input logic s, w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= s;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		// released lines show a changed value, not the last one
		hwdata <= ~d;
		haddr <= ~{24'h0, a};
	endtask
endmodule
`default_nettype wire

// ### dual_uart_host_signalling_tb.sv
// self-checking bench of the dual uart host port
`timescale 1ns/1ps
`default_nettype none
module dual_uart_host_signalling_tb;
	localparam logic [7:0] ID = 8'h3a; // arbitrary value
	localparam logic [7:0] REV = 8'h07; // arbitrary value
	localparam duart_pkg::level_t TRG = 7'h08; // trigger used
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, irq, a_irq, b_irq;
	logic [1:0] htrans, tx_push, rx_pop, rxq_n, txq_n, dir_rx;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [7:0] tx_data;
	logic [1:0][15:0] bdi;
	logic [1:0][3:0] bdf;
	logic [1:0][7:0] rx_data = '0;
	logic [1:0][6:0] rx_count = '0;
	logic [1:0][6:0] tx_count = '0;
	logic [1:0] tsr_empty = 2'h3;
	logic [1:0] rx_timeout = 2'h0;
	int n_mismatch = 0;
	int n_tests = 0;
	logic [31:0] expq[$]; // expected read data, oldest first
	logic [7:0] txq[$]; // expected transmit bytes
	logic [31:0] seed = 32'h0001600c; // starts at 90124
	logic rd_ph = 1'b0; // read data phase open
	logic [31:0] rst_v [8] = '{32'h1, 32'h0, 32'h0, 32'h0,
		32'h60, 32'h0, 32'h1, 32'h1};
	always #12.5 sys_clk = ~sys_clk;
	duart_host_port #(.ID_CODE(ID), .REV_CODE(REV)) dut (
		.sys_clk(sys_clk), .rstn(rstn), .ce(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .rx_data(rx_data),
		.rx_count(rx_count), .tx_count(tx_count), .tsr_empty(tsr_empty),
		.rx_timeout(rx_timeout), .tx_push(tx_push), .rx_pop(rx_pop),
		.tx_data(tx_data), .baud_int(bdi), .baud_frac(bdf),
		.rx_service_request_n(rxq_n), .tx_service_request_n(txq_n),
		.channel_a_irq(a_irq), .channel_b_irq(b_irq), .dir_rx(dir_rx),
		.irq(irq));
	cpu_model cpu (.sys_clk(sys_clk), .hreadyout(hreadyout),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata));
	// ********
	// helpers
	// ********
	function automatic logic [31:0] lfsr_step();
		seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
		return seed;
	endfunction
	// fill level with bias to the boundaries
	function automatic logic [6:0] cnt(input logic [31:0] v);
		case (v[2:0])
			3'h0: cnt = 7'h0;
			3'h1: cnt = 7'h40;
			3'h2: cnt = TRG;
			3'h3: cnt = TRG - 7'h1;
			default: cnt = 7'(v[14:8] % 65);
		endcase
	endfunction
	// pin status word, channel b left idle
	function automatic logic [31:0] pins(input logic [7:0] fc, ft,
		input logic [6:0] rc, tc, input logic ts, lat);
		logic au, txc, rxc, blk;
		au = ft[3];
		blk = fc[0] & fc[3];
		if (fc[0])
			txc = au ? (tc < TRG || (tc == 7'h0 && ts)) : tc <= TRG;
		else
			txc = au ? (tc == 7'h0 && ts) : tc == 7'h0;
		rxc = fc[0] ? rc >= TRG : rc != 7'h0;
		return {24'h0, 1'b1, !(au && (tc != 7'h0 || !ts)), 1'b0,
			blk ? tc == 7'h40 : tc != 7'h0, 1'b1,
			blk ? !lat : rc == 7'h0, 1'b1, txc | rxc};
	endfunction
	task automatic chk(input string what, input logic [31:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		cpu.xfer(1'b1, 1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		cpu.xfer(1'b1, 1'b0, a, 32'h0);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// monitor: compares each completed read and pushed byte
	always @(posedge sys_clk)
	begin
		if (rd_ph && hreadyout === 1'b1)
			chk("read data", expq.pop_front(), hrdata);
		if (hreadyout === 1'b1)
			rd_ph = hsel && htrans[1] && !hwrite;
		if (tx_push !== 2'h0)
			chk("tx byte", {24'h0, txq.pop_front()}, {24'h0, tx_data});
	end
	// watchdog
	initial
	begin
		#(25 * 20000);
		n_mismatch++;
		report_and_stop();
	end
	// ********
	// main sequence
	// ********
	initial
	begin
		logic [31:0] v, l;
		logic [7:0] fc, ft;
		logic [6:0] rc, tc;
		logic to, lat;
		lat = 1'b0;
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			rd(8'h44 + 8'(4 * i), rst_v[i]);
			rd(8'h04 + 8'(4 * i), rst_v[i]);
		end
		rd(8'h84, 32'h0);
		rd(8'h88, 32'hcf);
		$display("test reset values done");
		wr(8'h44, 32'h0);
		wr(8'h48, 32'h0);
		wr(8'h4c, 32'h9);
		rd(8'h48, {24'h0, ID});
		rd(8'h44, {24'h0, REV});
		rd(8'h04, 32'h1);
		wr(8'h44, 32'h9c);
		rd(8'h48, 32'h0);
		rd(8'h4c, 32'h9);
		chk("baud divisor", 32'h9009c, {12'h0, bdf[0], bdi[0]});
		$display("test identification done");
		for (int i = 9; i < 16; i++)
		begin
			v = lfsr_step();
			wr(8'h40 + 8'(4 * i), v);
			wr(8'(4 * i), ~v);
			rd(8'h40 + 8'(4 * i), {24'h0, v[7:0]});
			rd(8'(4 * i), {24'h0, ~v[7:0]});
		end
		cpu.xfer(1'b0, 1'b1, 8'h7c, 32'h0);
		rd(8'h7c, {24'h0, v[7:0]});
		wr(8'h54, 32'hff);
		rd(8'h54, 32'h60);
		wr(8'h8c, 32'hff);
		rd(8'h8c, 32'h0);
		txq.push_back(8'ha5);
		wr(8'h40, 32'ha5);
		$display("test register access done");
		wr(8'h5c, {25'h0, TRG});
		wr(8'h60, {25'h0, TRG});
		for (int m = 0; m < 6; m++)
		begin
			fc = (m % 3 == 0) ? 8'h0 : (m % 3 == 1) ? 8'h1 : 8'h9;
			ft = (m < 3) ? 8'h0 : 8'h8;
			wr(8'h50, {24'h0, fc});
			wr(8'h58, {24'h0, ft});
			for (int k = 0; k < 8; k++)
			begin
				v = lfsr_step();
				rc = (k == 0) ? 7'h0 : cnt(v);
				tc = cnt(v >> 8);
				to = v[21] && rc != 7'h0;
				lat = (rc >= TRG || to) ? 1'b1 : (rc == 7'h0) ? 1'b0 : lat;
				rx_count[0] <= rc;
				tx_count[0] <= tc;
				tsr_empty[0] <= v[20];
				rx_timeout[0] <= to;
				rx_data[0] <= v[31:24];
				repeat (2) @(posedge sys_clk);
				l = pins(fc, ft, rc, tc, v[20], lat);
				rd(8'h88, l);
				l = {25'h0, tc == 7'h0 && v[20],
					fc[0] ? tc != 7'h40 : tc == 7'h0, 4'h0, rc != 7'h0};
				rd(8'h54, l);
				rd(8'h40, {24'h0, v[31:24]});
			end
		end
		$display("test ready and interrupt pins done");
		wr(8'h50, 32'h1);
		wr(8'h58, 32'h0);
		rx_count[0] <= 7'h0;
		tx_count[0] <= TRG + 7'h2;
		repeat (3) @(posedge sys_clk);
		wr(8'h80, 32'hf);
		rd(8'h80, 32'h0);
		rx_count[0] <= TRG;
		repeat (3) @(posedge sys_clk);
		rd(8'h80, 32'h1);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(8'h84, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(8'h80, 32'h1);
		rd(8'h80, 32'h0);
		repeat (2) @(posedge sys_clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		txq.push_back(8'h5a);
		wr(8'h00, 32'h5a);
		$display("test status and mask done");
		repeat (3) @(posedge sys_clk);
		report_and_stop();
	end
endmodule
`default_nettype wire
